/* pkg/dsp_pkg.sv */
package dsp_pkg;

	////////////////////////////////////////////////////////////////////////
	// Widths
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int STRB_W = 4;
	localparam int TXN_ADDR_W = 28;
	localparam int NUM_BANKS = 8;
	localparam int BANK_W = 3;
	// Low address bits that pick the critical word
	localparam int CW_BITS = 2;

	////////////////////////////////////////////////////////////////////////
	// Build options
	localparam logic HAS_ACT_BYPASS = 1'b1;
	localparam logic HAS_RD_BYPASS = 1'b1;

	////////////////////////////////////////////////////////////////////////
	// Register map (byte addresses)
	localparam logic [ADDR_W-1:0] CTRL_OFFSET = 12'h028;
	localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'h040;

	// Control register fields
	localparam int BIT_ACT_BYP_DIS = 10;
	localparam int BIT_RD_BYP_DIS = 9;
	localparam int BIT_COLL_PAGE = 8;
	localparam int BIT_WC_DIS = 7;
	localparam int BIT_PREF_WR = 6;
	localparam int BIT_FORCE_LP_N = 5;
	localparam int BIT_AUTO_PRE = 4;
	localparam int BIT_CLOSE_PAGE = 3;

	localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0000;
	// Writable bits; absent bypass controls stay zero
	localparam logic [DATA_W-1:0] CTRL_WMASK =
		{21'h00_0000, HAS_ACT_BYPASS, HAS_RD_BYPASS, 6'h3F, 3'h0};

	// Status register fields
	localparam int STAT_PRE_LSB = 0;
	localparam int STAT_COLL_BIT = 8;
	localparam int STAT_FORCE_BIT = 9;
	localparam int STAT_SELW_BIT = 10;
	localparam int STAT_CLOSE_BIT = 11;

	////////////////////////////////////////////////////////////////////////
	// Bus phase tracking
	typedef enum logic [1:0] {
		DSP_APB_IDLE,
		DSP_APB_SETUP,
		DSP_APB_ACCESS
	} dsp_apb_e;

endpackage : dsp_pkg

/* hdl/dsp_collision.sv */
`timescale 1ns/1ps
module dsp_collision (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Incoming transaction
	input wire logic txn_valid_i,
	input wire logic txn_write_i,
	input wire logic [dsp_pkg::TXN_ADDR_W-1:0] txn_addr_i,
	// Policy
	input wire logic wc_disable_i,
	// Result for the current transaction
	output logic collision_o,
	output logic combine_o
);
	import dsp_pkg::*;

	logic last_valid_r;
	logic last_valid_nxt;
	logic last_write_r;
	logic last_write_nxt;
	logic [TXN_ADDR_W-1:0] last_addr_r;
	logic [TXN_ADDR_W-1:0] last_addr_nxt;
	logic same_addr;

	// Critical word bits never separate two accesses
	assign same_addr = last_valid_r &&
		(last_addr_r[TXN_ADDR_W-1:CW_BITS] ==
		txn_addr_i[TXN_ADDR_W-1:CW_BITS]);

	// Classify the pair formed with the previous transaction
	always_comb begin
		collision_o = 1'b0;
		combine_o = 1'b0;
		if (txn_valid_i && same_addr) begin
			if (last_write_r != txn_write_i) begin
				collision_o = 1'b1;
			end else if (txn_write_i) begin
				collision_o = wc_disable_i;
				combine_o = ~wc_disable_i;
			end
		end
	end

	// Remember the last accepted transaction
	always_comb begin
		last_valid_nxt = last_valid_r;
		last_write_nxt = last_write_r;
		last_addr_nxt = last_addr_r;
		if (txn_valid_i) begin
			last_valid_nxt = 1'b1;
			last_write_nxt = txn_write_i;
			last_addr_nxt = txn_addr_i;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			last_valid_r <= 1'b0;
			last_write_r <= 1'b0;
			last_addr_r <= '0;
		end else begin
			last_valid_r <= last_valid_nxt;
			last_write_r <= last_write_nxt;
			last_addr_r <= last_addr_nxt;
		end
	end

endmodule : dsp_collision

/* hdl/dsp_bank_close.sv */
`timescale 1ns/1ps
module dsp_bank_close (
	// Policy
	input wire logic close_page_i,
	// Bank state
	input wire logic [dsp_pkg::NUM_BANKS-1:0] bank_open_i,
	input wire logic [dsp_pkg::NUM_BANKS-1:0] bank_queued_i,
	input wire logic [dsp_pkg::NUM_BANKS-1:0] open_other_i,
	input wire logic [dsp_pkg::NUM_BANKS-1:0] page_timeout_i,
	input wire logic refresh_timeout_i,
	// Explicit precharge requests
	output logic [dsp_pkg::NUM_BANKS-1:0] precharge_o
);
	import dsp_pkg::*;

	// One decision per bank
	genvar b;
	generate
		for (b = 0; b < NUM_BANKS; b++) begin : g_bank
			logic need_close;
			logic idle_close;
			// Closing that is always required
			assign need_close = open_other_i[b] | page_timeout_i[b] |
				refresh_timeout_i;
			// Idle bank closing, held off while work to the page remains
			assign idle_close = close_page_i & ~bank_queued_i[b];
			assign precharge_o[b] = bank_open_i[b] &
				(need_close | idle_close);
		end
	endgenerate

endmodule : dsp_bank_close

/* hdl/dsp_top.sv */
`timescale 1ns/1ps
module dsp_top (
	// Clock and reset
	input wire logic CLK_SYS_I,
	input wire logic RST_B_I,
	// APB slave
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [dsp_pkg::ADDR_W-1:0] PADDR_I,
	input wire logic [dsp_pkg::DATA_W-1:0] PWDATA_I,
	input wire logic [dsp_pkg::STRB_W-1:0] PSTRB_I,
	output logic [dsp_pkg::DATA_W-1:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	// Incoming transaction
	input wire logic TXN_VALID_I,
	input wire logic TXN_WRITE_I,
	input wire logic TXN_HIPRI_I,
	input wire logic [dsp_pkg::TXN_ADDR_W-1:0] TXN_ADDR_I,
	output logic TXN_HIPRI_O,
	output logic COLLISION_O,
	output logic COMBINE_O,
	// Bypass candidates
	input wire logic RD_HIT_CAND_I,
	input wire logic ACT_CAND_I,
	output logic RD_BYPASS_O,
	output logic ACT_BYPASS_O,
	// Bank selection
	input wire logic [dsp_pkg::NUM_BANKS-1:0] RD_PEND_I,
	input wire logic [dsp_pkg::NUM_BANKS-1:0] WR_PEND_I,
	output logic SEL_VALID_O,
	output logic SEL_WRITE_O,
	output logic [dsp_pkg::BANK_W-1:0] SEL_BANK_O,
	// Column command form
	input wire logic CMD_VALID_I,
	input wire logic CMD_FLUSH_I,
	output logic CMD_AUTOPRE_O,
	// Page closing
	input wire logic AUTO_REFRESH_I,
	input wire logic [dsp_pkg::NUM_BANKS-1:0] BANK_OPEN_I,
	input wire logic [dsp_pkg::NUM_BANKS-1:0] BANK_QUEUED_I,
	input wire logic [dsp_pkg::NUM_BANKS-1:0] OPEN_OTHER_I,
	input wire logic [dsp_pkg::NUM_BANKS-1:0] PAGE_TIMEOUT_I,
	input wire logic REFRESH_TIMEOUT_I,
	output logic [dsp_pkg::NUM_BANKS-1:0] PRECHARGE_O
);
	import dsp_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Register select: bit 1 control, bit 0 status
	function automatic logic [1:0] reg_decode(
		input logic [ADDR_W-1:0] addr
	);
		reg_decode = {addr == CTRL_OFFSET, addr == STATUS_OFFSET};
	endfunction : reg_decode

	// Lowest numbered bank with a pending request
	function automatic logic [BANK_W-1:0] first_bank(
		input logic [NUM_BANKS-1:0] pend
	);
		first_bank = '0;
		for (int i = NUM_BANKS - 1; i >= 0; i--) begin
			if (pend[i]) begin
				first_bank = BANK_W'(i);
			end
		end
	endfunction : first_bank

	////////////////////////////////////////////////////////////////////////
	// Declarations

	dsp_apb_e apb_r;
	dsp_apb_e apb_nxt;
	logic [DATA_W-1:0] ctrl_r;
	logic [DATA_W-1:0] ctrl_nxt;
	logic [DATA_W-1:0] prdata_r;
	logic [DATA_W-1:0] prdata_nxt;
	logic [DATA_W-1:0] lane_mask;
	logic [DATA_W-1:0] status_word;
	logic [1:0] dec_now;
	logic bus_setup;
	logic bus_access;

	logic act_byp_dis;
	logic rd_byp_dis;
	logic coll_page;
	logic wc_dis;
	logic pref_wr;
	logic force_lp_n;
	logic auto_pre;
	logic close_page;
	logic close_eff;

	logic coll_now;
	logic comb_now;
	logic [NUM_BANKS-1:0] pre_now;
	logic wr_any;
	logic rd_any;

	logic hipri_r;
	logic hipri_nxt;
	logic coll_r;
	logic coll_nxt;
	logic comb_r;
	logic comb_nxt;
	logic rd_byp_r;
	logic rd_byp_nxt;
	logic act_byp_r;
	logic act_byp_nxt;
	logic sel_valid_r;
	logic sel_valid_nxt;
	logic sel_write_r;
	logic sel_write_nxt;
	logic [BANK_W-1:0] sel_bank_r;
	logic [BANK_W-1:0] sel_bank_nxt;
	logic autopre_r;
	logic autopre_nxt;
	logic [NUM_BANKS-1:0] pre_r;
	logic [NUM_BANKS-1:0] pre_nxt;

	////////////////////////////////////////////////////////////////////////
	// APB slave

	// Phase decode and fields of the control word
	assign bus_setup = PSEL_I & ~PENABLE_I;
	assign bus_access = PSEL_I & PENABLE_I;
	assign dec_now = reg_decode(PADDR_I);
	assign act_byp_dis = ctrl_r[BIT_ACT_BYP_DIS];
	assign rd_byp_dis = ctrl_r[BIT_RD_BYP_DIS];
	assign coll_page = ctrl_r[BIT_COLL_PAGE];
	assign wc_dis = ctrl_r[BIT_WC_DIS];
	assign pref_wr = ctrl_r[BIT_PREF_WR];
	assign force_lp_n = ctrl_r[BIT_FORCE_LP_N];
	assign auto_pre = ctrl_r[BIT_AUTO_PRE];
	assign close_page = ctrl_r[BIT_CLOSE_PAGE];

	// Zero wait states; unmapped addresses answer with an error
	assign PREADY_O = 1'b1;
	assign PSLVERR_O = bus_access & ~(|dec_now);
	assign PRDATA_O = prdata_r;

	// Live scheduler state seen by software
	always_comb begin
		status_word = '0;
		status_word[STAT_PRE_LSB +: NUM_BANKS] = pre_r;
		status_word[STAT_COLL_BIT] = coll_r;
		status_word[STAT_FORCE_BIT] = ~force_lp_n;
		status_word[STAT_SELW_BIT] = sel_write_r;
		status_word[STAT_CLOSE_BIT] = close_eff;
	end

	// Byte lanes that a write may touch
	always_comb begin
		lane_mask = '0;
		for (int l = 0; l < STRB_W; l++) begin
			lane_mask[l*8 +: 8] = {8{PSTRB_I[l]}};
		end
		lane_mask = lane_mask & CTRL_WMASK;
	end

	// Next bus phase, control word and read data
	always_comb begin
		apb_nxt = DSP_APB_IDLE;
		ctrl_nxt = ctrl_r;
		prdata_nxt = prdata_r;
		case (apb_r)
			DSP_APB_IDLE, DSP_APB_ACCESS: begin
				if (bus_setup) begin
					apb_nxt = DSP_APB_SETUP;
				end
			end
			DSP_APB_SETUP: begin
				apb_nxt = bus_access ? DSP_APB_ACCESS : DSP_APB_IDLE;
			end
			default: begin
				apb_nxt = DSP_APB_IDLE;
			end
		endcase
		// Read data is ready by the access phase
		if (bus_setup && !PWRITE_I) begin
			prdata_nxt = '0;
			if (dec_now[1]) begin
				prdata_nxt = ctrl_r & CTRL_WMASK;
			end else if (dec_now[0]) begin
				prdata_nxt = status_word;
			end
		end
		// Writes land on the access edge of a proper transfer only
		if (bus_access && (apb_r == DSP_APB_SETUP) && PWRITE_I &&
			dec_now[1]) begin
			ctrl_nxt = (ctrl_r & ~lane_mask) | (PWDATA_I & lane_mask);
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			apb_r <= DSP_APB_IDLE;
			ctrl_r <= CTRL_RESET;
			prdata_r <= '0;
		end else begin
			apb_r <= apb_nxt;
			ctrl_r <= ctrl_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Collision and combining

	dsp_collision u_collision (
		.clk_i(CLK_SYS_I),
		.rst_b_i(RST_B_I),
		.txn_valid_i(TXN_VALID_I),
		.txn_write_i(TXN_WRITE_I),
		.txn_addr_i(TXN_ADDR_I),
		.wc_disable_i(wc_dis),
		.collision_o(coll_now),
		.combine_o(comb_now)
	);

	////////////////////////////////////////////////////////////////////////
	// Page closing

	// Close-page has no meaning under auto-refresh
	assign close_eff = close_page & ~AUTO_REFRESH_I;

	dsp_bank_close u_bank_close (
		.close_page_i(close_eff),
		.bank_open_i(BANK_OPEN_I),
		.bank_queued_i(BANK_QUEUED_I),
		.open_other_i(OPEN_OTHER_I),
		.page_timeout_i(PAGE_TIMEOUT_I),
		.refresh_timeout_i(REFRESH_TIMEOUT_I),
		.precharge_o(pre_now)
	);

	////////////////////////////////////////////////////////////////////////
	// Scheduling decisions

	assign wr_any = |WR_PEND_I;
	assign rd_any = |RD_PEND_I;

	// Next decision values
	always_comb begin
		hipri_nxt = TXN_VALID_I & TXN_HIPRI_I & force_lp_n;
		coll_nxt = coll_now;
		comb_nxt = comb_now;
		// Bypass needs the build option, no disable and no forcing
		rd_byp_nxt = HAS_RD_BYPASS & ~rd_byp_dis & force_lp_n &
			RD_HIT_CAND_I;
		act_byp_nxt = HAS_ACT_BYPASS & ~act_byp_dis & force_lp_n &
			ACT_CAND_I;
		// Writes win when preferred, else only when no read waits
		sel_valid_nxt = wr_any | rd_any;
		sel_write_nxt = wr_any & (pref_wr | ~rd_any);
		sel_bank_nxt = sel_write_nxt ? first_bank(WR_PEND_I) :
			first_bank(RD_PEND_I);
		// Auto-precharge form, never in close-page mode
		autopre_nxt = CMD_VALID_I & auto_pre & ~close_eff &
			~(CMD_FLUSH_I & ~coll_page);
		pre_nxt = pre_now;
	end

	always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			hipri_r <= 1'b0;
			coll_r <= 1'b0;
			comb_r <= 1'b0;
			rd_byp_r <= 1'b0;
			act_byp_r <= 1'b0;
			sel_valid_r <= 1'b0;
			sel_write_r <= 1'b0;
			sel_bank_r <= '0;
			autopre_r <= 1'b0;
			pre_r <= '0;
		end else begin
			hipri_r <= hipri_nxt;
			coll_r <= coll_nxt;
			comb_r <= comb_nxt;
			rd_byp_r <= rd_byp_nxt;
			act_byp_r <= act_byp_nxt;
			sel_valid_r <= sel_valid_nxt;
			sel_write_r <= sel_write_nxt;
			sel_bank_r <= sel_bank_nxt;
			autopre_r <= autopre_nxt;
			pre_r <= pre_nxt;
		end
	end

	// Registered decision outputs
	assign TXN_HIPRI_O = hipri_r;
	assign COLLISION_O = coll_r;
	assign COMBINE_O = comb_r;
	assign RD_BYPASS_O = rd_byp_r;
	assign ACT_BYPASS_O = act_byp_r;
	assign SEL_VALID_O = sel_valid_r;
	assign SEL_WRITE_O = sel_write_r;
	assign SEL_BANK_O = sel_bank_r;
	assign CMD_AUTOPRE_O = autopre_r;
	assign PRECHARGE_O = pre_r;

endmodule : dsp_top

/* sim/dsp_dram_model.sv */
`timescale 1ns/1ps
module dsp_dram_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_b_i,
	// Row commands
	input wire logic [dsp_pkg::NUM_BANKS-1:0] activate_i,
	input wire logic [dsp_pkg::NUM_BANKS-1:0] precharge_i,
	// Row state
	output logic [dsp_pkg::NUM_BANKS-1:0] bank_open_o
);
	import dsp_pkg::*;
	logic [NUM_BANKS-1:0] open_r, open_nxt;
	// Precharge closes a row, activate opens one
	always_comb begin
		open_nxt = (open_r & ~precharge_i) | activate_i;
	end
	// Row state register
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			open_r <= '0;
		end else begin
			open_r <= open_nxt;
		end
	end
	assign bank_open_o = open_r;
endmodule : dsp_dram_model

/* sim/dsp_top_properties.sv */
`timescale 1ns/1ps
module dsp_checker (
	// Bus
	input wire logic CLK_SYS_I, RST_B_I, PSEL_I, PENABLE_I, PWRITE_I,
	input wire logic [dsp_pkg::ADDR_W-1:0] PADDR_I,
	input wire logic [dsp_pkg::DATA_W-1:0] PWDATA_I, PRDATA_O,
	input wire logic [dsp_pkg::STRB_W-1:0] PSTRB_I,
	// Scheduler
	input wire logic TXN_VALID_I, TXN_WRITE_I, TXN_HIPRI_I, TXN_HIPRI_O,
	input wire logic COLLISION_O, COMBINE_O, RD_HIT_CAND_I, ACT_CAND_I,
	input wire logic RD_BYPASS_O, ACT_BYPASS_O, SEL_WRITE_O, CMD_VALID_I,
	input wire logic CMD_FLUSH_I, CMD_AUTOPRE_O, AUTO_REFRESH_I,
	input wire logic REFRESH_TIMEOUT_I,
	input wire logic [dsp_pkg::TXN_ADDR_W-1:0] TXN_ADDR_I,
	input wire logic [dsp_pkg::NUM_BANKS-1:0] RD_PEND_I, WR_PEND_I,
	input wire logic [dsp_pkg::NUM_BANKS-1:0] BANK_OPEN_I, BANK_QUEUED_I,
	input wire logic [dsp_pkg::NUM_BANKS-1:0] OPEN_OTHER_I, PAGE_TIMEOUT_I,
	input wire logic [dsp_pkg::NUM_BANKS-1:0] PRECHARGE_O
);
	import dsp_pkg::*;
	logic [DATA_W-1:0] ctl_r, ctl_nxt;
	logic [TXN_ADDR_W-1:0] pa_r, pa_nxt;
	logic pw_r, pw_nxt, hv_r, hv_nxt, lv_r, hit, ce;
	logic [10:3] c;
	// Shadow control register and last accepted transaction
	always_comb begin
		ctl_nxt = ctl_r;
		if (PSEL_I && PENABLE_I && PWRITE_I && PADDR_I == CTRL_OFFSET) begin
			for (int i = 0; i < STRB_W; i++) begin
				if (PSTRB_I[i]) begin
					ctl_nxt[8*i+:8] = PWDATA_I[8*i+:8];
				end
			end
		end
		ctl_nxt = ctl_nxt & CTRL_WMASK;
		{hv_nxt, pw_nxt, pa_nxt} = {hv_r, pw_r, pa_r};
		if (TXN_VALID_I) begin
			{hv_nxt, pw_nxt, pa_nxt} = {1'b1, TXN_WRITE_I, TXN_ADDR_I};
		end
	end
	// Shadow registers
	always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
		if (!RST_B_I) begin
			{ctl_r, pa_r, pw_r, hv_r, lv_r} <= '0;
		end else begin
			{ctl_r, pa_r, pw_r, hv_r, lv_r} <= {ctl_nxt, pa_nxt, pw_nxt, hv_nxt, 1'b1};
		end
	end
	// Address match ignores the critical word bits
	assign hit = hv_r && TXN_VALID_I && TXN_ADDR_I[TXN_ADDR_W-1:CW_BITS]
		== pa_r[TXN_ADDR_W-1:CW_BITS];
	assign ce = c[3] && !AUTO_REFRESH_I;
	assign c = ctl_r[10:3];
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RST_B_I);
	////////////////////////////////////////////////////////////////////////
	a_act_bypass_gate: assert property (
		lv_r |-> ACT_BYPASS_O == $past(ACT_CAND_I && !c[10] && c[5]))
		else $error("activate bypass grant wrong");
	a_rd_bypass_gate: assert property (
		lv_r |-> RD_BYPASS_O == $past(RD_HIT_CAND_I && !c[9] && c[5]))
		else $error("read bypass grant wrong");
	a_forced_low_pri: assert property (
		lv_r |-> TXN_HIPRI_O == $past(TXN_VALID_I && TXN_HIPRI_I && c[5]))
		else $error("priority output wrong");
	a_collision_pairs: assert property (
		lv_r |-> COLLISION_O == $past(hit && (TXN_WRITE_I != pw_r
		|| (TXN_WRITE_I && c[7])))) else $error("collision flag wrong");
	a_write_combine: assert property (
		hit && TXN_WRITE_I && pw_r |=> COMBINE_O == !$past(c[7]))
		else $error("combine flag wrong");
	a_autopre_form: assert property (
		lv_r |-> CMD_AUTOPRE_O == $past(CMD_VALID_I && c[4] && !ce
		&& !(CMD_FLUSH_I && !c[8]))) else $error("autoprecharge form wrong");
	a_write_pref: assert property (
		lv_r |-> SEL_WRITE_O == $past(|WR_PEND_I && (c[6] || !(|RD_PEND_I))))
		else $error("bank selection class wrong");
	a_page_close: assert property (
		lv_r |-> PRECHARGE_O == $past(BANK_OPEN_I & (OPEN_OTHER_I
		| PAGE_TIMEOUT_I | {NUM_BANKS{REFRESH_TIMEOUT_I}}
		| ({NUM_BANKS{ce}} & ~BANK_QUEUED_I)))) else $error("precharge wrong");
	a_ctrl_readback: assert property (
		PSEL_I && PENABLE_I && !PWRITE_I && PADDR_I == CTRL_OFFSET
		|-> PRDATA_O == ctl_r) else $error("control readback wrong");
	c_collision: cover property (COLLISION_O);
	c_combine: cover property (COMBINE_O);
	c_act_bypass: cover property (ACT_BYPASS_O);
endmodule : dsp_checker
bind dsp_top dsp_checker u_dsp_checker (.*);

/* sim/ddr2_scheduler_policy_control_tb.sv */
`timescale 1ns/1ps
module ddr2_scheduler_policy_control_tb;
	import dsp_pkg::*;
	// Design inputs
	logic CLK_SYS_I = 1'b0, RST_B_I = 1'b0, PSEL_I = 1'b0, PENABLE_I = 1'b0;
	logic PWRITE_I = 1'b0, TXN_VALID_I = 1'b0, TXN_WRITE_I = 1'b0;
	logic TXN_HIPRI_I = 1'b0, RD_HIT_CAND_I = 1'b0, ACT_CAND_I = 1'b0;
	logic CMD_VALID_I = 1'b0, CMD_FLUSH_I = 1'b0, AUTO_REFRESH_I = 1'b0;
	logic REFRESH_TIMEOUT_I = 1'b0;
	logic [ADDR_W-1:0] PADDR_I = '0;
	logic [DATA_W-1:0] PWDATA_I = '0;
	logic [STRB_W-1:0] PSTRB_I = '0;
	logic [TXN_ADDR_W-1:0] TXN_ADDR_I = '0;
	logic [NUM_BANKS-1:0] RD_PEND_I = '0, WR_PEND_I = '0, BANK_QUEUED_I = '0;
	logic [NUM_BANKS-1:0] OPEN_OTHER_I = '0, PAGE_TIMEOUT_I = '0, act = '0;
	// Design outputs
	logic [DATA_W-1:0] PRDATA_O;
	logic PREADY_O, PSLVERR_O, TXN_HIPRI_O, COLLISION_O, COMBINE_O;
	logic RD_BYPASS_O, ACT_BYPASS_O, SEL_VALID_O, SEL_WRITE_O, CMD_AUTOPRE_O;
	logic [BANK_W-1:0] SEL_BANK_O;
	logic [NUM_BANKS-1:0] PRECHARGE_O, BANK_OPEN_I;
	// Bench state
	logic [DATA_W-1:0] c = '0, d, r;
	logic [TXN_ADDR_W-1:0] pa = '0;
	logic [18:0] x, g;
	logic pw = 1'b0, hv = 1'b0, armed, err;
	logic [STRB_W-1:0] s;
	int failures = 0, comparisons = 0, cycles = 0;

	dsp_top dut (.*);
	dsp_dram_model u_dram (.clk_i(CLK_SYS_I), .rst_b_i(RST_B_I),
		.activate_i(act), .precharge_i(PRECHARGE_O), .bank_open_o(BANK_OPEN_I));

	// Clock and hang limit
	always #2.5 CLK_SYS_I = ~CLK_SYS_I;
	always @(posedge CLK_SYS_I) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] gv, input logic [31:0] xv);
		comparisons++;
		if (gv !== xv) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, gv, xv);
		end
	endtask : chk
	// One APB transfer, called just after a rising edge
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] wd, input logic [STRB_W-1:0] st,
		output logic [DATA_W-1:0] rd, output logic e);
		PSEL_I <= 1'b1;
		PWRITE_I <= w;
		PADDR_I <= a;
		PWDATA_I <= wd;
		PSTRB_I <= st;
		@(posedge CLK_SYS_I);
		PENABLE_I <= 1'b1;
		do @(posedge CLK_SYS_I); while (PREADY_O !== 1'b1);
		rd = PRDATA_O;
		e = PSLVERR_O;
		PSEL_I <= 1'b0;
		PENABLE_I <= 1'b0;
	endtask : apb
	// Expected decisions for the inputs now on the pins
	function automatic logic [18:0] predict(input logic [10:3] k);
		logic hit, sw, ce;
		logic [NUM_BANKS-1:0] pd;
		logic [BANK_W-1:0] bk;
		hit = hv && TXN_VALID_I && TXN_ADDR_I[TXN_ADDR_W-1:CW_BITS]
			== pa[TXN_ADDR_W-1:CW_BITS];
		sw = |WR_PEND_I && (k[6] || !(|RD_PEND_I));
		pd = sw ? WR_PEND_I : RD_PEND_I;
		bk = '0;
		for (int i = NUM_BANKS - 1; i >= 0; i--) begin
			if (pd[i]) begin
				bk = BANK_W'(i);
			end
		end
		ce = k[3] && !AUTO_REFRESH_I;
		return {TXN_VALID_I && TXN_HIPRI_I && k[5],
			hit && (TXN_WRITE_I != pw || (TXN_WRITE_I && k[7])),
			hit && TXN_WRITE_I && pw && !k[7],
			RD_HIT_CAND_I && !k[9] && k[5], ACT_CAND_I && !k[10] && k[5],
			|(RD_PEND_I | WR_PEND_I), sw, bk,
			CMD_VALID_I && k[4] && !ce && !(CMD_FLUSH_I && !k[8]),
			BANK_OPEN_I & (OPEN_OTHER_I | PAGE_TIMEOUT_I |
			{NUM_BANKS{REFRESH_TIMEOUT_I}} | ({NUM_BANKS{ce}} & ~BANK_QUEUED_I))};
	endfunction : predict
	task automatic end_of_test;
		$display("comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_of_test
	////////////////////////////////////////////////////////////////////////
	// Reset, register checks, then random traffic per control setting
	initial begin
		void'($urandom(59));
		repeat (8) @(posedge CLK_SYS_I);
		RST_B_I <= 1'b1;
		@(posedge CLK_SYS_I);
		apb(1'b0, CTRL_OFFSET, '0, '0, r, err);
		chk(r, 32'h0);
		chk(32'(err), 32'h0);
		// Status after reset: only the forced low priority flag is up
		@(posedge CLK_SYS_I);
		apb(1'b0, STATUS_OFFSET, '0, '0, r, err);
		chk(r, 32'h1 << STAT_FORCE_BIT);
		@(posedge CLK_SYS_I);
		apb(1'b1, 12'h100, '1, 4'hF, r, err);
		chk(32'(err), 32'h1);
		@(posedge CLK_SYS_I);
		apb(1'b0, 12'h100, '0, '0, r, err);
		chk(r, 32'h0);
		chk(32'(err), 32'h1);
		for (int p = 0; p < 8; p++) begin
			d = (p == 0) ? 32'h0 : (p == 1) ? '1 : $urandom;
			s = (p < 2) ? 4'hF : STRB_W'($urandom);
			@(posedge CLK_SYS_I);
			apb(1'b1, CTRL_OFFSET, d, s, r, err);
			for (int i = 0; i < STRB_W; i++) begin
				if (s[i]) begin
					c[8*i+:8] = d[8*i+:8];
				end
			end
			c = c & CTRL_WMASK;
			@(posedge CLK_SYS_I);
			apb(1'b0, CTRL_OFFSET, '0, '0, r, err);
			chk(r, c);
			chk(32'(err), 32'h0);
			armed = 1'b0;
			repeat (300) begin
				@(posedge CLK_SYS_I);
				{TXN_VALID_I, TXN_WRITE_I, TXN_HIPRI_I, RD_HIT_CAND_I, ACT_CAND_I,
					CMD_VALID_I, CMD_FLUSH_I, AUTO_REFRESH_I} <= 8'($urandom);
				REFRESH_TIMEOUT_I <= ($urandom % 8) == 0;
				TXN_ADDR_I <= TXN_ADDR_W'($urandom % 8);
				{RD_PEND_I, WR_PEND_I, BANK_QUEUED_I, act} <= $urandom;
				OPEN_OTHER_I <= NUM_BANKS'($urandom & $urandom & $urandom);
				PAGE_TIMEOUT_I <= NUM_BANKS'($urandom & $urandom & $urandom);
				@(negedge CLK_SYS_I);
				g = {TXN_HIPRI_O, COLLISION_O, COMBINE_O, RD_BYPASS_O, ACT_BYPASS_O,
					SEL_VALID_O, SEL_WRITE_O, SEL_BANK_O, CMD_AUTOPRE_O, PRECHARGE_O};
				if (armed) begin
					chk(32'(g[18]), 32'(x[18]));
					chk(32'(g[17:16]), 32'(x[17:16]));
					chk(32'(g[15:14]), 32'(x[15:14]));
					chk(32'(g[13:9]), 32'(x[13:9]));
					chk(32'(g[8]), 32'(x[8]));
					chk(32'(g[7:0]), 32'(x[7:0]));
					chk(32'(g[7:0]), 32'(x[7:0]));
				end
				x = predict(c[10:3]);
				if (TXN_VALID_I) begin
					{hv, pw, pa} = {1'b1, TXN_WRITE_I, TXN_ADDR_I};
				end
				armed = 1'b1;
			end
			@(posedge CLK_SYS_I);
			TXN_VALID_I <= 1'b0;
		end
		end_of_test();
	end
endmodule : ddr2_scheduler_policy_control_tb
